// file: hw/mode_seq_pkg.sv
package mode_seq_pkg;

    // Register map of the die-to-die port.
    localparam logic [7:0] MODE_CTRL_OFFSET = 8'h16;
    localparam int         MODE_FIELD_LSB   = 0;
    localparam int         MODE_FIELD_W     = 2;
    localparam logic [1:0] MODE_CTRL_RESET  = 2'h0;

    // Mode select encodings.
    localparam logic [1:0] MODE_WAKE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_STOP        = 2'h1;
    localparam logic [1:0] MODE_SLEEP       = 2'h2;
    localparam logic [1:0] MODE_NORMAL      = 2'h3;

    // Timing.
    localparam int CLK_FREQ_MHZ      = 25;
    localparam int RST_EXT_TIME_US   = 100;
    localparam int RST_EXT_CYCLES    = RST_EXT_TIME_US * CLK_FREQ_MHZ;
    localparam int WAKE_READ_GAP_CYC = 2;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_NORMAL,
        ST_STOP,
        ST_SLEEP
    } op_state_t;

    // Comparator levels from the analog supply monitors.
    typedef struct packed {
        logic io_ok;
        logic core_ok;
        logic battery_low;
        logic main_low;
        logic highside_high;
        logic reg_overvolt;
        logic high_temp;
        logic over_temp;
    } supply_sense_t;

    // Registered warning outputs.
    typedef struct packed {
        logic low_battery_irq;
        logic low_voltage_irq;
        logic high_voltage_irq;
        logic regulator_overvoltage_irq;
        logic high_temp_irq;
        logic core_undervoltage_reset;
        logic io_undervoltage_reset;
        logic overtemp_shutdown;
    } supply_warn_t;

endpackage : mode_seq_pkg

// file: hw/reset_stretch.sv
`timescale 1ns/1ps
module reset_stretch #(
    parameter int EXT_CYCLES = mode_seq_pkg::RST_EXT_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic nrst,
    input  wire logic cond,
    output logic      active
);

    localparam int CW = $clog2(EXT_CYCLES + 1);

    logic [CW-1:0] count_ff;

    // Reload while the condition stands, then count the extension down.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count_ff <= CW'(EXT_CYCLES);
        end else if (cond) begin
            count_ff <= CW'(EXT_CYCLES); // [R17]
        end else if (count_ff != '0) begin
            count_ff <= count_ff - CW'(1);
        end
    end

    assign active = cond || (count_ff != '0); // [R17]

    property p_stretch_hold;
        @(posedge core_clk) disable iff (!nrst)
        $fell(cond) |-> active ##1 active;
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) // [R17]
        else $error("Reset released without extension.");

endmodule : reset_stretch

// file: hw/mode_and_supply_sequencer.sv
// Overview of operation
// R1: Mode field write starts selected transition; 11 Normal.
// R2: Value 00 wakes Stop to Normal only.
// R3: Value 01 enters Stop mode.
// R4: Value 10 enters Sleep, regulators off.
// R5: Host reads wake source before next Stop.
// R6: Host waits two cycles after that read.
// R7: Normal starts watchdog initial period; else disabled.
// R8: Sensor supply switched by its own control; code also holds it off outside Normal.
// R9: Core regulator enabled only after IO good.
// R10: Reset output released after core good.
// R11: IO low: core off, discharged, reset asserted.
// R12: Low battery and low voltage warnings raised.
// R13: High voltage warning from highside supply.
// R14: Overvoltage warning from either regulator.
// R15: Separate resets for core and IO undervoltage.
// R16: High temperature warning and overtemperature shutdown.
// R17: Reset output held for extension after condition.
// R18: Sleep wake or reset goes to Reset.
// R19: Stop wake-up signalled by an interrupt.
// R20: Upper control bits read zero, reset zero.
`timescale 1ns/1ps
module mode_and_supply_sequencer #(
    parameter int RST_EXT_CYCLES = mode_seq_pkg::RST_EXT_CYCLES
) (
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic [7:0]                       reg_rdata_ff,
    input  wire logic                        wake_src_rd,
    input  wire logic                        wake_evt,
    input  wire logic                        wd_served,
    input  wire logic                        sensor_supply_req,
    input  wire mode_seq_pkg::supply_sense_t sense,
    output mode_seq_pkg::supply_warn_t       warn_ff,
    output mode_seq_pkg::op_state_t          state_ff,
    output logic                             io_reg_en_ff,
    output logic                             core_reg_en_ff,
    output logic                             core_discharge_ff,
    output logic                             reset_a_n_ff,
    output logic                             watchdog_en_ff,
    output logic                             wd_initial_ff,
    output logic                             sensor_supply_out_ff,
    output logic                             stop_wake_irq_ff
);

    mode_seq_pkg::op_state_t nxt_state;
    logic [1:0]              mode_sel_ff;
    logic                    stop_ok_ff;
    logic [1:0]              rd_dly_ff;
    logic                    mode_wr;
    logic                    fault;
    logic                    rst_cond;
    logic                    rst_active;

    assign mode_wr  = reg_wr && (reg_addr == mode_seq_pkg::MODE_CTRL_OFFSET);
    assign fault    = !sense.io_ok || !sense.core_ok || sense.over_temp; // [R15] [R16]
    assign rst_cond = fault || (state_ff == mode_seq_pkg::ST_SLEEP);

    reset_stretch #(
        .EXT_CYCLES (RST_EXT_CYCLES)
    ) u_stretch (
        .core_clk (core_clk),
        .nrst     (nrst),
        .cond     (rst_cond),
        .active   (rst_active)
    );

    // Mode select field; upper bits are not stored.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_sel_ff <= mode_seq_pkg::MODE_CTRL_RESET; // [R20]
        end else if (mode_wr) begin
            mode_sel_ff <= reg_wdata[mode_seq_pkg::MODE_FIELD_LSB +: mode_seq_pkg::MODE_FIELD_W];
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= (reg_addr == mode_seq_pkg::MODE_CTRL_OFFSET) ?
                            {6'h00, mode_sel_ff} : 8'h00; // [R20]
        end
    end

    // Stop is re-armed two cycles after the wake source is read; the set wins.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_dly_ff  <= 2'h0;
            stop_ok_ff <= 1'b1;
        end else begin
            rd_dly_ff <= {rd_dly_ff[0], wake_src_rd};
            if (rd_dly_ff[mode_seq_pkg::WAKE_READ_GAP_CYC-1]) begin
                stop_ok_ff <= 1'b1; // [R5] [R6]
            end else if (state_ff == mode_seq_pkg::ST_STOP && nxt_state != state_ff) begin
                stop_ok_ff <= 1'b0; // [R5]
            end
        end
    end

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            mode_seq_pkg::ST_RESET: begin
                if (!rst_active) begin
                    nxt_state = mode_seq_pkg::ST_NORMAL; // [R10]
                end
            end
            mode_seq_pkg::ST_NORMAL: begin
                if (fault) begin
                    nxt_state = mode_seq_pkg::ST_RESET; // [R15]
                end else if (mode_wr && reg_wdata[1:0] == mode_seq_pkg::MODE_STOP
                             && stop_ok_ff) begin
                    nxt_state = mode_seq_pkg::ST_STOP; // [R1] [R3]
                end else if (mode_wr && reg_wdata[1:0] == mode_seq_pkg::MODE_SLEEP) begin
                    nxt_state = mode_seq_pkg::ST_SLEEP; // [R4]
                end
            end
            mode_seq_pkg::ST_STOP: begin
                if (fault) begin
                    nxt_state = mode_seq_pkg::ST_RESET;
                end else if (mode_wr && reg_wdata[1:0] == mode_seq_pkg::MODE_SLEEP) begin
                    nxt_state = mode_seq_pkg::ST_SLEEP; // [R4]
                end else if (wake_evt || (mode_wr && (reg_wdata[1:0] == mode_seq_pkg::MODE_NORMAL
                             || reg_wdata[1:0] == mode_seq_pkg::MODE_WAKE_NORMAL))) begin
                    nxt_state = mode_seq_pkg::ST_NORMAL; // [R1] [R2]
                end
            end
            mode_seq_pkg::ST_SLEEP: begin
                if (wake_evt || sense.over_temp) begin
                    nxt_state = mode_seq_pkg::ST_RESET; // [R18]
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= mode_seq_pkg::ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stop_wake_irq_ff <= 1'b0;
        end else begin
            stop_wake_irq_ff <= (state_ff == mode_seq_pkg::ST_STOP)
                                && (nxt_state == mode_seq_pkg::ST_NORMAL); // [R19]
        end
    end

    // Supply sequencing.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            io_reg_en_ff      <= 1'b0;
            core_reg_en_ff    <= 1'b0;
            core_discharge_ff <= 1'b1;
            reset_a_n_ff      <= 1'b0;
        end else begin
            io_reg_en_ff      <= (nxt_state != mode_seq_pkg::ST_SLEEP) && !sense.over_temp; // [R4]
            core_reg_en_ff    <= (nxt_state != mode_seq_pkg::ST_SLEEP) && !sense.over_temp
                                 && sense.io_ok; // [R9] [R11]
            core_discharge_ff <= !sense.io_ok; // [R11]
            reset_a_n_ff      <= !rst_active; // [R10] [R11] [R17]
        end
    end

    // Mode-gated functions.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            watchdog_en_ff       <= 1'b0;
            wd_initial_ff        <= 1'b0;
            sensor_supply_out_ff <= 1'b0;
        end else begin
            watchdog_en_ff       <= (nxt_state == mode_seq_pkg::ST_NORMAL); // [R7]
            sensor_supply_out_ff <= sensor_supply_req
                                    && (nxt_state == mode_seq_pkg::ST_NORMAL); // [R8]
            if (nxt_state == mode_seq_pkg::ST_NORMAL && state_ff != mode_seq_pkg::ST_NORMAL) begin
                wd_initial_ff <= 1'b1; // [R7]
            end else if (wd_served || nxt_state != mode_seq_pkg::ST_NORMAL) begin
                wd_initial_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            warn_ff <= '0;
        end else begin
            warn_ff.low_battery_irq           <= sense.battery_low; // [R12]
            warn_ff.low_voltage_irq           <= sense.main_low; // [R12]
            warn_ff.high_voltage_irq          <= sense.highside_high; // [R13]
            warn_ff.regulator_overvoltage_irq <= sense.reg_overvolt; // [R14]
            warn_ff.high_temp_irq             <= sense.high_temp; // [R16]
            warn_ff.core_undervoltage_reset   <= !sense.core_ok; // [R15]
            warn_ff.io_undervoltage_reset     <= !sense.io_ok; // [R15]
            warn_ff.overtemp_shutdown         <= sense.over_temp; // [R16]
        end
    end

    property p_core_after_io;
        @(posedge core_clk) disable iff (!nrst)
        $rose(core_reg_en_ff) |-> $past(sense.io_ok);
    endproperty
    a_core_after_io: assert property (p_core_after_io) // [R9]
        else $error("Core regulator enabled before IO good.");

    property p_release_core_ok;
        @(posedge core_clk) disable iff (!nrst)
        $rose(reset_a_n_ff) |-> $past(sense.core_ok && sense.io_ok);
    endproperty
    a_release_core_ok: assert property (p_release_core_ok) // [R10]
        else $error("Reset released with core low.");

    property p_io_drop;
        @(posedge core_clk) disable iff (!nrst)
        !sense.io_ok |=> !core_reg_en_ff && core_discharge_ff && !reset_a_n_ff;
    endproperty
    a_io_drop: assert property (p_io_drop) // [R11]
        else $error("IO drop not handled.");

    property p_stop_entry;
        @(posedge core_clk) disable iff (!nrst)
        state_ff == mode_seq_pkg::ST_NORMAL && !fault && stop_ok_ff && mode_wr
        && reg_wdata[1:0] == mode_seq_pkg::MODE_STOP |=> state_ff == mode_seq_pkg::ST_STOP;
    endproperty
    a_stop_entry: assert property (p_stop_entry) // [R3]
        else $error("Stop not entered.");

    property p_stop_blocked;
        @(posedge core_clk) disable iff (!nrst)
        state_ff == mode_seq_pkg::ST_NORMAL && !stop_ok_ff && !rd_dly_ff[1] && mode_wr
        && reg_wdata[1:0] == mode_seq_pkg::MODE_STOP |=> state_ff != mode_seq_pkg::ST_STOP;
    endproperty
    a_stop_blocked: assert property (p_stop_blocked) // [R5]
        else $error("Stop accepted before wake source read.");

    property p_sleep_entry;
        @(posedge core_clk) disable iff (!nrst)
        state_ff == mode_seq_pkg::ST_NORMAL && !fault && mode_wr
        && reg_wdata[1:0] == mode_seq_pkg::MODE_SLEEP |=> state_ff == mode_seq_pkg::ST_SLEEP
        && !io_reg_en_ff && !core_reg_en_ff;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) // [R4]
        else $error("Sleep not entered with regulators off.");

    property p_wake_zero;
        @(posedge core_clk) disable iff (!nrst)
        state_ff == mode_seq_pkg::ST_STOP && !fault && mode_wr
        && reg_wdata[1:0] == mode_seq_pkg::MODE_WAKE_NORMAL
        |=> state_ff == mode_seq_pkg::ST_NORMAL && stop_wake_irq_ff;
    endproperty
    a_wake_zero: assert property (p_wake_zero) // [R2]
        else $error("Zero write did not wake from Stop.");

    property p_zero_ignored;
        @(posedge core_clk) disable iff (!nrst)
        state_ff == mode_seq_pkg::ST_NORMAL && !fault && mode_wr
        && reg_wdata[1:0] == mode_seq_pkg::MODE_WAKE_NORMAL |=> $stable(state_ff);
    endproperty
    a_zero_ignored: assert property (p_zero_ignored) // [R2]
        else $error("Zero write had effect outside Stop.");

    property p_wd_off;
        @(posedge core_clk) disable iff (!nrst)
        state_ff != mode_seq_pkg::ST_NORMAL |-> !watchdog_en_ff && !wd_initial_ff;
    endproperty
    a_wd_off: assert property (p_wd_off) // [R7]
        else $error("Watchdog active outside Normal.");

    property p_sleep_wake;
        @(posedge core_clk) disable iff (!nrst)
        state_ff == mode_seq_pkg::ST_SLEEP && wake_evt |=> state_ff == mode_seq_pkg::ST_RESET;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) // [R18]
        else $error("Sleep wake did not enter Reset.");

    property p_rdata_upper;
        @(posedge core_clk) disable iff (!nrst)
        reg_rdata_ff[7:2] == 6'h00;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper) // [R20]
        else $error("Reserved mode bits read nonzero.");

    c_stop_wake: cover property (@(posedge core_clk) disable iff (!nrst)
        state_ff == mode_seq_pkg::ST_STOP ##1 stop_wake_irq_ff);
    c_sleep_reset: cover property (@(posedge core_clk) disable iff (!nrst)
        state_ff == mode_seq_pkg::ST_SLEEP ##1 state_ff == mode_seq_pkg::ST_RESET);
    c_power_up: cover property (@(posedge core_clk) disable iff (!nrst)
        $rose(reset_a_n_ff));

endmodule : mode_and_supply_sequencer

// file: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata_ff,
    input  wire logic       stop_wake_irq_ff,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            wake_src_rd
);
    logic need_wake_read;
    int   since_wake_read;

    initial begin
        reg_addr        = 8'h00;
        reg_wdata       = 8'h00;
        reg_wr          = 1'b0;
        reg_rd          = 1'b0;
        wake_src_rd     = 1'b0;
        need_wake_read  = 1'b0;
        since_wake_read = 8;
    end

    // A Stop wake-up means the wake source must be read before the next Stop.
    always @(posedge stop_wake_irq_ff) need_wake_read = 1'b1;

    always @(posedge core_clk) begin
        if (since_wake_read < 8) since_wake_read++;
    end

    task automatic write_raw(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        #1;
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask : write_raw

    task automatic read_wake_src();
        @(posedge core_clk);
        #1;
        wake_src_rd = 1'b1;
        @(posedge core_clk);
        #1;
        wake_src_rd     = 1'b0;
        since_wake_read = 0;
        need_wake_read  = 1'b0;
    endtask : read_wake_src

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        if (addr == mode_seq_pkg::MODE_CTRL_OFFSET) begin
            if (data[1:0] == mode_seq_pkg::MODE_STOP && need_wake_read) read_wake_src();
            while (since_wake_read < mode_seq_pkg::WAKE_READ_GAP_CYC) begin
                @(posedge core_clk);
                #1;
            end
        end
        write_raw(addr, data);
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        #1;
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(posedge core_clk);
        #1;
        data     = reg_rdata_ff;
        reg_rd   = 1'b0;
        reg_addr = ~addr;
    endtask : read_reg
endmodule : host_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
    localparam int RST_EXT = 4;
    logic                        core_clk;
    logic                        nrst;
    logic [7:0]                  reg_addr, reg_wdata, reg_rdata_ff, rd;
    logic                        reg_wr, reg_rd, wake_src_rd, wake_evt, wd_served;
    logic                        sensor_supply_req, io_reg_en_ff, core_reg_en_ff;
    logic                        core_discharge_ff, reset_a_n_ff, watchdog_en_ff;
    logic                        wd_initial_ff, sensor_supply_out_ff, stop_wake_irq_ff, seen;
    mode_seq_pkg::supply_sense_t sense;
    mode_seq_pkg::supply_warn_t  warn_ff;
    mode_seq_pkg::op_state_t     state_ff;
    int                          errors, check_count, cnt;

    mode_and_supply_sequencer #(.RST_EXT_CYCLES(RST_EXT)) i_mode_and_supply_sequencer (
        .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .wake_src_rd(wake_src_rd), .wake_evt(wake_evt), .wd_served(wd_served),
        .sensor_supply_req(sensor_supply_req), .sense(sense), .warn_ff(warn_ff),
        .state_ff(state_ff), .io_reg_en_ff(io_reg_en_ff), .core_reg_en_ff(core_reg_en_ff),
        .core_discharge_ff(core_discharge_ff), .reset_a_n_ff(reset_a_n_ff),
        .watchdog_en_ff(watchdog_en_ff), .wd_initial_ff(wd_initial_ff),
        .sensor_supply_out_ff(sensor_supply_out_ff), .stop_wake_irq_ff(stop_wake_irq_ff));

    host_model i_host_model (
        .core_clk(core_clk), .reg_rdata_ff(reg_rdata_ff), .stop_wake_irq_ff(stop_wake_irq_ff),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .wake_src_rd(wake_src_rd));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1

    task automatic chk_state(input mode_seq_pkg::op_state_t exp);
        chk8({6'h00, state_ff}, {6'h00, exp});
    endtask : chk_state

    task automatic wait_release();
        cnt = 0;
        while (reset_a_n_ff !== 1'b1 && cnt < 50) begin
            tick(1);
            cnt++;
        end
        chk1(cnt >= RST_EXT && cnt < 50, 1'b1);
    endtask : wait_release

    task automatic stop_test();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test

    initial begin
        #(40 * 3000);
        errors++;
        stop_test();
    end

    initial begin
        errors = 0;
        check_count = 0;
        nrst = 1'b0;
        wake_evt = 1'b0;
        wd_served = 1'b0;
        sensor_supply_req = 1'b0;
        sense = 8'h00;
        tick(4);
        nrst = 1'b1;
        i_host_model.read_reg(8'h16, rd);
        chk8(rd, 8'h00);
        chk1(io_reg_en_ff, 1'b1);
        chk1(core_reg_en_ff, 1'b0);
        sense.io_ok = 1'b1;
        tick(3);
        chk1(core_reg_en_ff, 1'b1);
        chk1(reset_a_n_ff, 1'b0);
        sense.core_ok = 1'b1;
        wait_release();
        chk_state(mode_seq_pkg::ST_NORMAL);
        chk1(watchdog_en_ff & wd_initial_ff, 1'b1);
        wd_served = 1'b1;
        tick(1);
        wd_served = 1'b0;
        sensor_supply_req = 1'b1;
        tick(2);
        chk1(wd_initial_ff, 1'b0);
        chk1(sensor_supply_out_ff, 1'b1);
        i_host_model.write_raw(8'h16, 8'hFD);
        chk_state(mode_seq_pkg::ST_STOP);
        chk1(watchdog_en_ff, 1'b0);
        i_host_model.read_reg(8'h16, rd);
        chk8(rd, 8'h01);
        chk1(sensor_supply_out_ff, 1'b0);
        i_host_model.write_raw(8'h16, 8'h00);
        chk_state(mode_seq_pkg::ST_NORMAL);
        chk1(stop_wake_irq_ff, 1'b1);
        i_host_model.write_raw(8'h16, 8'h01);
        chk_state(mode_seq_pkg::ST_NORMAL);
        i_host_model.write_raw(8'h16, 8'h00);
        chk_state(mode_seq_pkg::ST_NORMAL);
        chk1(stop_wake_irq_ff, 1'b0);
        i_host_model.write_reg(8'h16, 8'h01);
        chk_state(mode_seq_pkg::ST_STOP);
        i_host_model.write_raw(8'h16, 8'h03);
        chk_state(mode_seq_pkg::ST_NORMAL);
        i_host_model.write_reg(8'h16, 8'h01);
        chk_state(mode_seq_pkg::ST_STOP);
        wake_evt = 1'b1;
        tick(1);
        wake_evt = 1'b0;
        seen = stop_wake_irq_ff;
        tick(1);
        seen = seen | stop_wake_irq_ff;
        chk1(seen, 1'b1);
        chk_state(mode_seq_pkg::ST_NORMAL);
        sensor_supply_req = 1'b0;
        tick(1);
        chk1(sensor_supply_out_ff, 1'b0);
        chk1(io_reg_en_ff & core_reg_en_ff, 1'b1);
        i_host_model.write_raw(8'h17, 8'h02);
        i_host_model.read_reg(8'h16, rd);
        chk8(rd, 8'h01);
        i_host_model.read_reg(8'h17, rd);
        chk8(rd, 8'h00);
        i_host_model.write_raw(8'h16, 8'h02);
        chk_state(mode_seq_pkg::ST_SLEEP);
        tick(1);
        chk1(io_reg_en_ff | core_reg_en_ff | watchdog_en_ff, 1'b0);
        wake_evt = 1'b1;
        tick(1);
        wake_evt = 1'b0;
        tick(1);
        chk_state(mode_seq_pkg::ST_RESET);
        wait_release();
        for (int i = 0; i < 5; i++) begin
            sense = 8'hC0 | (8'h20 >> i);
            tick(2);
            chk8(warn_ff, 8'h80 >> i);
        end
        sense = 8'h80;
        tick(2);
        chk8(warn_ff, 8'h04);
        chk1(reset_a_n_ff, 1'b0);
        sense = 8'hC1;
        tick(2);
        chk8(warn_ff, 8'h01);
        chk1(io_reg_en_ff | core_reg_en_ff | reset_a_n_ff, 1'b0);
        sense = 8'hC0;
        wait_release();
        sense = 8'h40;
        tick(1);
        chk1(core_reg_en_ff | reset_a_n_ff, 1'b0);
        chk1(core_discharge_ff, 1'b1);
        chk_state(mode_seq_pkg::ST_RESET);
        tick(1);
        chk8(warn_ff, 8'h02);
        stop_test();
    end
endmodule : tb
